/* verilog/wdt_dt_pkg.sv */
// Purpose: constants, map and helpers for the watchdog / discharge timer block
// Assumes: 125 MHz system clock, Avalon-MM word addressing
// Notes: time bases are in ms ticks; discharge lengths are in half-minutes
package wdt_dt_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int WDT_S = 2;
  localparam int WDT_MS = WDT_S * 1000;
  localparam int HALF_MIN_S = 30;
  localparam int HALF_MIN_MS = HALF_MIN_S * 1000;
  // ==========================================================
  // word offsets (byte address is four times these)
  localparam logic [5:0] A_CFGA_LO = 6'h00;
  localparam logic [5:0] A_CFGA_HI = 6'h01;
  localparam logic [5:0] A_CFGB = 6'h02;
  localparam logic [5:0] A_SWITCH_CONTROL_GROUP = 6'h03;
  localparam logic [5:0] A_PSB = 6'h04;
  localparam logic [5:0] A_OVUV = 6'h05;
  localparam logic [5:0] A_STATB = 6'h06;
  // ==========================================================
  // fields, masks, reset values
  localparam int DISCHARGE_TIMEOUT_CODE_LSB = 44;
  localparam int DISCHARGE_MONITOR_ENABLE_BIT = 11;
  localparam logic [47:0] CFGA_B0_M = 48'h0000_0000_00FF;
  localparam logic [47:0] CFGA_B13_M = 48'h0000_FFFF_FF00;
  localparam logic [47:0] CFGA_B45_M = 48'hFFFF_0000_0000;
  localparam logic [15:0] CFGB_GPIO_M = 16'h000F;
  localparam logic [15:0] CFGB_MUTE_M = 16'h8000;
  localparam logic [47:0] CFGA_RST = 48'h0000_0000_0000;
  localparam logic [15:0] CFGB_RST = 16'h0000;
  localparam logic [31:0] SWITCH_CONTROL_GROUP_RST = 32'h0000_0000;
  localparam logic [7:0] PSB_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'hFFFF;
  localparam logic [29:0] OVUV_RST = 30'h0000_0000;
  // result memory indexes
  localparam int IDX_CELL_LAST = 14;
  localparam int IDX_AUX_FIRST = 16;
  localparam int IDX_AUX_KEEP = 26;
  localparam int IDX_SC = 28;
  localparam int IDX_VD = 31;
  // status word bits
  localparam int SB_THERMAL_SHUTDOWN_FLAG = 0;
  localparam int SB_MUX = 1;
  localparam int SB_REV_LSB = 4;
  localparam int SB_WDX = 8;
  localparam int SB_DTRUN = 9;
  // ==========================================================
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_WRITE_CONFIG_A_CMD = 3'b001, CMD_READ_CONFIG_A_CMD = 3'b010, CMD_READ_STATUS_B_CMD = 3'b011,
    CMD_CLEAR_CELL_RESULTS_CMD = 3'b100, CMD_CLEAR_AUXILIARY_CMD = 3'b101, CMD_CLEAR_STATUS_CMD = 3'b110, CMD_OTHER = 3'b111
  } cmd_t;

  // timeout code to length in half-minutes
  function automatic logic [7:0] dc_len(input logic [3:0] code);
    case (code)
      4'h1: dc_len = 8'h01;
      4'h2: dc_len = 8'h02;
      4'h3: dc_len = 8'h04;
      4'h4: dc_len = 8'h06;
      4'h5: dc_len = 8'h08;
      4'h6: dc_len = 8'h0A;
      4'h7: dc_len = 8'h14;
      4'h8: dc_len = 8'h1E;
      4'h9: dc_len = 8'h28;
      4'hA: dc_len = 8'h3C;
      4'hB: dc_len = 8'h50;
      4'hC: dc_len = 8'h78;
      4'hD: dc_len = 8'h96;
      4'hE: dc_len = 8'hB4;
      4'hF: dc_len = 8'hF0;
      default: dc_len = 8'h00;
    endcase
  endfunction

  // remaining half-minutes to the smallest bin that holds them
  function automatic logic [3:0] dc_bin(input logic [7:0] rem);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 15; i >= 1; i--) begin
      if (rem <= dc_len(4'(i))) c = 4'(i);
    end
    if (rem == 8'h00) c = 4'h0;
    return c;
  endfunction
endpackage

/* verilog/wdt_dt_ctl.sv */
// Purpose: command watchdog, discharge timer, thermal flag and result clears
// Assumes: inputs synchronous to clk_sys; commands arrive pre-decoded
// Notes: registers on Avalon-MM slave, word addressed
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// [R1] watchdog expires after 2 s without command
// [R2] expiry resets byte0, gpio, bytes1-3 if monitor off
// [R3] timer off: expiry also resets bytes4-5, switches, cfgb
// [R4] expiry releases open-drain watchdog pin
// [R5] watchdog always on, restarts on good command
// [R6] running discharge timer keeps switches through expiry
// [R7] enable pin high: switches on for code duration
// [R8] code 0 off, 1..F select 0.5..120 min
// [R9] pin low or code 0: expiry resets everything
// [R10] discharge expiry resets bytes4-5, switches, cfgb part
// [R11] readback code shows remaining time
// [R12] thermal event resets config, switches off, flag
// [R13] read status B clears thermal flag
// [R14] clear status sets thermal flag, keeps config
// [R15] clear cells sets cell results to FF
// [R16] clear aux sets aux, keeps last D words
// [R17] clear status keeps revision, reserved read zero
// [R18] clear status sets ov/uv, mux, thermal flags
// [R19] clear status sets SC, INTERNAL_TEMPERATURE_RESULT, VA, VD FF
// [R20] revision field fully visible for error code
// [R21] discharge timer restarts only on config A write
// [R22] readback 0 when disabled or expired, bins
// [R23] prescaled timers, reset clears everything
module wdt_dt_ctl
  import wdt_dt_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int HALF_MIN_TICKS = HALF_MIN_MS,
  parameter logic [3:0] REV_CODE = 4'h5 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic discharge_timer_enable_pin,
  input wire logic cmd_valid,
  input wire logic cmd_pec_ok,
  input wire cmd_t cmd_code,
  input wire logic thermal_event,
  input wire logic ovuv_load,
  input wire logic [29:0] ovuv_val,
  input wire logic mux_done,
  input wire logic mux_fail,
  input wire logic adc_wr,
  input wire logic [4:0] adc_idx,
  input wire logic [15:0] adc_data,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic watchdog_output_pin_o,
  output logic watchdog_output_pin_oe,
  output logic [14:0] discharge_sw,
  output logic thermal_shutdown_flag
);
  // ==========================================================
  // elaboration checks
  if (TICK_CYCLES < 2 || HALF_MIN_TICKS < 2 || HALF_MIN_TICKS > 32767) begin : g_chk
    $error("timer parameters out of range");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [11:0] WD_LAST = 12'(WDT_MS - 1);
  localparam logic [14:0] HM_LAST = 15'(HALF_MIN_TICKS - 1);

  // ==========================================================
  // bus slave
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d, rd_word;
  logic wr_ack;
  logic [47:0] cfga_q, cfga_d;
  logic [15:0] cfgb_q, cfgb_d;
  logic [31:0] switch_control_group_q, switch_control_group_d;
  logic [7:0] psb_q, psb_d;
  logic [29:0] ovuv_q, ovuv_d;
  logic thermal_shutdown_flag_q, thermal_shutdown_flag_d, mux_q, mux_d;
  logic [15:0] res_q [0:31];
  logic [15:0] res_d [0:31];
  logic wd_exp_q, wd_exp_d;
  logic [7:0] dt_rem_q, dt_rem_d;
  logic dt_run;
  logic [3:0] discharge_timeout_code_rd;

  assign wr_ack = avs_write && !wait_q;
  assign dt_run = discharge_timer_enable_pin && (cfga_q[DISCHARGE_TIMEOUT_CODE_LSB +: 4] != 4'h0) && (dt_rem_q != 8'h00); // [R9]
  assign discharge_timeout_code_rd = dt_run ? dc_bin(dt_rem_q) : 4'h0; // [R22]

  always_comb begin
    rd_word = 32'h0000_0000;
    if (avs_address[5]) begin
      rd_word = {16'h0000, res_q[avs_address[4:0]]};
    end else begin
      case (avs_address)
        A_CFGA_LO: rd_word = cfga_q[31:0];
        A_CFGA_HI: rd_word = {16'h0000, discharge_timeout_code_rd, cfga_q[43:32]}; // [R11]
        A_CFGB: rd_word = {16'h0000, cfgb_q};
        A_SWITCH_CONTROL_GROUP: rd_word = switch_control_group_q;
        A_PSB: rd_word = {24'h0000_00, psb_q};
        A_OVUV: rd_word = {2'b00, ovuv_q};
        A_STATB: begin
          rd_word[SB_THERMAL_SHUTDOWN_FLAG] = thermal_shutdown_flag_q;
          rd_word[SB_MUX] = mux_q;
          rd_word[SB_REV_LSB +: 4] = REV_CODE; // [R20] [R17]
          rd_word[SB_WDX] = wd_exp_q;
          rd_word[SB_DTRUN] = dt_run;
        end
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      if (avs_read) rdata_d = rd_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ==========================================================
  // timers
  logic [PW-1:0] pre_q, pre_d;
  logic [11:0] wd_ms_q, wd_ms_d;
  logic [14:0] hm_q, hm_d;
  logic tick, vcmd, wd_fire, dt_fire, oe_q, oe_d;
  logic [14:0] sw_q, sw_d;

  assign tick = (pre_q == PRE_LAST); // [R23]
  assign vcmd = cmd_valid && cmd_pec_ok;
  assign wd_fire = tick && !wd_exp_q && (wd_ms_q == WD_LAST) && !vcmd; // [R1]
  assign dt_fire = dt_run && tick && (hm_q == HM_LAST) && (dt_rem_q == 8'h01);

  always_comb begin
    pre_d = tick ? '0 : pre_q + 1'b1;
    wd_ms_d = wd_ms_q;
    wd_exp_d = wd_exp_q;
    hm_d = hm_q;
    dt_rem_d = dt_rem_q;
    if (vcmd) begin
      wd_ms_d = 12'h000; // [R5]
      wd_exp_d = 1'b0;
    end else if (tick && !wd_exp_q) begin
      if (wd_ms_q == WD_LAST) wd_exp_d = 1'b1; // [R1]
      else wd_ms_d = wd_ms_q + 12'h001;
    end
    if (vcmd && cmd_code == CMD_WRITE_CONFIG_A_CMD) begin
      hm_d = 15'h0000; // [R21]
      dt_rem_d = discharge_timer_enable_pin ? dc_len(cfga_q[DISCHARGE_TIMEOUT_CODE_LSB +: 4]) : 8'h00; // [R7] [R8]
    end else if (!dt_run) begin
      dt_rem_d = 8'h00;
    end else if (tick) begin
      if (hm_q == HM_LAST) begin
        hm_d = 15'h0000;
        dt_rem_d = dt_rem_q - 8'h01;
      end else begin
        hm_d = hm_q + 15'h0001;
      end
    end
    oe_d = !wd_exp_d; // [R4]
    // thermal cuts switches at once; other resets act through the config bits
    sw_d = thermal_event ? 15'h0000 : {cfgb_q[6:4], cfga_q[43:40], cfga_q[39:32]}; // [R12] [R6]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_q <= '0;
      wd_ms_q <= 12'h000;
      wd_exp_q <= 1'b0;
      hm_q <= 15'h0000;
      dt_rem_q <= 8'h00;
      oe_q <= 1'b1;
      sw_q <= 15'h0000;
    end else if (ce) begin
      pre_q <= pre_d;
      wd_ms_q <= wd_ms_d;
      wd_exp_q <= wd_exp_d;
      hm_q <= hm_d;
      dt_rem_q <= dt_rem_d;
      oe_q <= oe_d;
      sw_q <= sw_d;
    end
  end

  assign watchdog_output_pin_o = 1'b0;
  assign watchdog_output_pin_oe = oe_q;
  assign discharge_sw = sw_q;

  // ==========================================================
  // configuration groups
  logic [47:0] ma;
  logic [15:0] mb;
  logic ms, full, discharge_monitor_enable;

  assign discharge_monitor_enable = cfgb_q[DISCHARGE_MONITOR_ENABLE_BIT];
  assign full = (wd_fire && !dt_run) || (dt_fire && wd_exp_q); // [R3] [R9]

  always_comb begin
    ma = 48'h0000_0000_0000;
    mb = 16'h0000;
    ms = full;
    if (full) begin
      ma = ~48'h0000_0000_0000;
      mb = ~16'h0000;
    end
    if (wd_fire && dt_run) begin
      ma = ma | CFGA_B0_M | (discharge_monitor_enable ? 48'h0000_0000_0000 : CFGA_B13_M); // [R2]
      mb = mb | CFGB_GPIO_M;
    end
    if (dt_fire && !wd_exp_q) begin
      ma = ma | CFGA_B45_M | (discharge_monitor_enable ? CFGA_B13_M : 48'h0000_0000_0000); // [R10]
      mb = mb | ~(CFGB_GPIO_M | CFGB_MUTE_M);
      ms = 1'b1;
    end
    if (thermal_event) begin
      ma = ~48'h0000_0000_0000; // [R12]
      mb = mb | ~CFGB_MUTE_M;
    end
    cfga_d = (cfga_q & ~ma) | (CFGA_RST & ma);
    cfgb_d = (cfgb_q & ~mb) | (CFGB_RST & mb);
    switch_control_group_d = ms ? SWITCH_CONTROL_GROUP_RST : switch_control_group_q;
    psb_d = ms ? PSB_RST : psb_q;
    // new write data lands after any reset of the same cycle
    if (wr_ack && !avs_address[5]) begin
      case (avs_address)
        A_CFGA_LO: cfga_d[31:0] = be_merge(cfga_d[31:0], avs_writedata, avs_byteenable);
        A_CFGA_HI: cfga_d[47:32] = 16'(be_merge({16'h0000, cfga_d[47:32]}, avs_writedata, avs_byteenable));
        A_CFGB: cfgb_d = 16'(be_merge({16'h0000, cfgb_d}, avs_writedata, avs_byteenable));
        A_SWITCH_CONTROL_GROUP: switch_control_group_d = be_merge(switch_control_group_d, avs_writedata, avs_byteenable);
        A_PSB: psb_d = 8'(be_merge({24'h0000_00, psb_d}, avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfga_q <= CFGA_RST; // [R23]
      cfgb_q <= CFGB_RST;
      switch_control_group_q <= SWITCH_CONTROL_GROUP_RST;
      psb_q <= PSB_RST;
    end else if (ce) begin
      cfga_q <= cfga_d;
      cfgb_q <= cfgb_d;
      switch_control_group_q <= switch_control_group_d;
      psb_q <= psb_d;
    end
  end

  // ==========================================================
  // status flags and results
  logic c_cell, c_aux, c_stat, rd_stb;
  assign c_cell = vcmd && cmd_code == CMD_CLEAR_CELL_RESULTS_CMD;
  assign c_aux = vcmd && cmd_code == CMD_CLEAR_AUXILIARY_CMD;
  assign c_stat = vcmd && cmd_code == CMD_CLEAR_STATUS_CMD;
  assign rd_stb = vcmd && cmd_code == CMD_READ_STATUS_B_CMD;

  always_comb begin
    thermal_shutdown_flag_d = thermal_shutdown_flag_q;
    if (rd_stb) thermal_shutdown_flag_d = 1'b0; // [R13]
    if (thermal_event || c_stat) thermal_shutdown_flag_d = 1'b1; // [R12] [R14]
    mux_d = mux_done ? mux_fail : mux_q;
    ovuv_d = ovuv_load ? ovuv_val : ovuv_q;
    if (c_stat) begin
      mux_d = 1'b1; // [R18]
      ovuv_d = ~30'h0000_0000;
    end
    for (int i = 0; i < 32; i++) begin
      res_d[i] = res_q[i];
      if (adc_wr && adc_idx == 5'(i)) res_d[i] = adc_data;
      if (c_cell && i <= IDX_CELL_LAST) res_d[i] = 16'hFFFF; // [R15]
      if (c_aux && i >= IDX_AUX_FIRST && i < IDX_AUX_KEEP) res_d[i] = 16'hFFFF; // [R16]
      if (c_stat && i >= IDX_AUX_KEEP && i <= IDX_VD) res_d[i] = 16'hFFFF; // [R18] [R19]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      thermal_shutdown_flag_q <= 1'b0;
      mux_q <= 1'b1;
      ovuv_q <= OVUV_RST;
      for (int i = 0; i < 32; i++) res_q[i] <= RES_RST;
    end else if (ce) begin
      thermal_shutdown_flag_q <= thermal_shutdown_flag_d;
      mux_q <= mux_d;
      ovuv_q <= ovuv_d;
      for (int i = 0; i < 32; i++) res_q[i] <= res_d[i];
    end
  end

  assign thermal_shutdown_flag = thermal_shutdown_flag_q;

  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_req_seen;
    ce && (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack_then_idle;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_ack_pulse: assert property (s_req_seen ##1 ce |-> s_ack_then_idle) // [R23]
    else $error("waitrequest handshake broken");
  a_wd_pin_release: assert property (ce && wd_fire |=> !watchdog_output_pin_oe) // [R4]
    else $error("watchdog pin not released");
  a_wd_restart: assert property (ce && vcmd |=> wd_ms_q == 12'h000 && !wd_exp_q ##1 watchdog_output_pin_oe) // [R5]
    else $error("watchdog not restarted");
  a_wd_period: assert property (ce && tick && wd_ms_q == WD_LAST && !wd_exp_q && !vcmd |=> wd_exp_q) // [R1]
    else $error("watchdog did not expire");
  a_dt_keep_sw: assert property (ce && wd_fire && dt_run && !dt_fire && !thermal_event && !wr_ack
    |=> cfga_q[47:32] == $past(cfga_q[47:32])) // [R6]
    else $error("switch bits lost on expiry");
  a_dt_load: assert property (ce && vcmd && cmd_code == CMD_WRITE_CONFIG_A_CMD && discharge_timer_enable_pin
    |=> dt_rem_q == dc_len($past(cfga_q[47:44])) && hm_q == 15'h0000) // [R21]
    else $error("discharge timer not loaded");
  a_full_reset: assert property (ce && wd_fire && !dt_run && !wr_ack |=> cfga_q == CFGA_RST && switch_control_group_q == SWITCH_CONTROL_GROUP_RST) // [R9]
    else $error("full reset missing");
  a_thermal_set: assert property (ce && thermal_event |=> thermal_shutdown_flag_q && discharge_sw == 15'h0000) // [R12]
    else $error("thermal event not handled");
  a_thermal_shutdown_flag_clear: assert property (ce && rd_stb && !thermal_event |=> !thermal_shutdown_flag_q) // [R13]
    else $error("thermal flag not cleared");
  a_clr_cells: assert property (ce && c_cell |=> res_q[0] == 16'hFFFF && res_q[IDX_CELL_LAST] == 16'hFFFF) // [R15]
    else $error("cell results not cleared");
  a_readback_off: assert property (ce && dt_fire && !vcmd |=> discharge_timeout_code_rd == 4'h0 && !dt_run) // [R22]
    else $error("readback code not zero");
  a_clr_aux: assert property (ce && c_aux && !adc_wr
    |=> res_q[IDX_AUX_FIRST] == 16'hFFFF && res_q[IDX_AUX_KEEP] == $past(res_q[IDX_AUX_KEEP])) // [R16]
    else $error("aux results not cleared");
  a_clr_stat: assert property (ce && c_stat |=> thermal_shutdown_flag_q && mux_q && ovuv_q == ~30'h0000_0000
    && res_q[IDX_SC] == 16'hFFFF && res_q[IDX_VD] == 16'hFFFF) // [R18] [R19]
    else $error("status clear incomplete");
  a_stat_keeps_cfg: assert property (ce && c_stat && !thermal_event && !wr_ack && !wd_fire && !dt_fire
    |=> cfga_q == $past(cfga_q)) // [R14]
    else $error("status clear touched config");
  a_dt_expire: assert property (ce && dt_fire && !wd_exp_q && !wr_ack
    |=> switch_control_group_q == SWITCH_CONTROL_GROUP_RST && cfga_q[47:32] == 16'h0000) // [R10]
    else $error("discharge expiry reset missing");
  a_wd_partial: assert property (ce && wd_fire && dt_run && !wr_ack
    |=> cfga_q[7:0] == 8'h00 && cfgb_q[3:0] == 4'h0) // [R2]
    else $error("partial watchdog reset missing");
  a_dt_no_restart: assert property (ce && vcmd && cmd_code != CMD_WRITE_CONFIG_A_CMD && dt_run && !tick
    |=> dt_rem_q == $past(dt_rem_q) && hm_q == $past(hm_q)) // [R21]
    else $error("discharge timer restarted");
  // overtemperature must not be hidden by a status read in the same cycle
  a_thermal_shutdown_flag_set_wins: assert property (ce && rd_stb && thermal_event |=> thermal_shutdown_flag_q) // [R12] [R13]
    else $error("thermal flag lost to read clear");
endmodule

/* testbench/host_cmd_model.sv */
// Purpose: host side of the command link, issues pre-decoded commands
// Assumes: caller enters send right after a rising edge of clk_sys
// Notes: each command is a one-cycle pulse followed by one idle cycle
`timescale 1ns/1ps
module host_cmd_model
  import wdt_dt_pkg::*;
(
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic cmd_pec_ok,
  output cmd_t cmd_code
);
  // ==========================================================
  // idle state
  initial begin
    cmd_valid = 1'b0;
    cmd_pec_ok = 1'b0;
    cmd_code = CMD_NONE;
  end
  // ==========================================================
  // command pulse; idle cycle after so no signal is set twice in one step
  task automatic send(input cmd_t c, input logic ok);
    cmd_valid <= 1'b1;
    cmd_pec_ok <= ok;
    cmd_code <= c;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_pec_ok <= 1'b0;
    cmd_code <= CMD_NONE;
    @(posedge clk_sys);
  endtask
endmodule

/* testbench/tb_watchdog_discharge_timer_reset_ctl.sv */
// Purpose: self-checking bench for the watchdog / discharge timer block
// Assumes: 1 tick = 4 cycles, half-minute = 40 ticks (160 cycles)
// Notes: watchdog span is 2000 ticks = 8000 cycles
`timescale 1ns/1ps
module tb_watchdog_discharge_timer_reset_ctl;
  import wdt_dt_pkg::*;
  // ==========================================================
  // signals
  logic clk_sys = 1'b0, sys_rst = 1'b1, pin = 1'b0, th = 1'b0, ovl = 1'b0;
  logic mxd = 1'b0, aw = 1'b0, rd = 1'b0, wr = 1'b0, pin_o, pin_oe, thf, wq;
  logic [4:0] ai = 5'h00;
  logic [15:0] ad = 16'h0000;
  logic [5:0] adr = 6'h00;
  logic [29:0] ov = 30'h0000_0000;
  logic [31:0] wd = 32'h0000_0000, rdata, rq, el, eb;
  logic [14:0] sw;
  logic cv, cok;
  cmd_t cc;
  int error_cnt = 0;
  int checked = 0;
  int ix[7] = '{0, 14, 16, 25, 26, 28, 31};
  always #4 clk_sys = ~clk_sys;
  host_cmd_model host (.clk_sys(clk_sys), .cmd_valid(cv), .cmd_pec_ok(cok), .cmd_code(cc));
  wdt_dt_ctl #(.TICK_CYCLES(4), .HALF_MIN_TICKS(40)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .discharge_timer_enable_pin(pin),
    .cmd_valid(cv), .cmd_pec_ok(cok), .cmd_code(cc), .thermal_event(th),
    .ovuv_load(ovl), .ovuv_val(ov), .mux_done(mxd), .mux_fail(1'b0),
    .adc_wr(aw), .adc_idx(ai), .adc_data(ad), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rq),
    .avs_waitrequest(wq), .watchdog_output_pin_o(pin_o), .watchdog_output_pin_oe(pin_oe),
    .discharge_sw(sw), .thermal_shutdown_flag(thf));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    rdata = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rdata & m, e);
  endtask
  task automatic rres(input logic [4:0] i, input logic [31:0] e);
    rchk("result", {1'b1, i}, 32'hFFFF_FFFF, e);
  endtask
  // one-cycle strobe on any of th, mxd, ovl, aw
  task automatic pulse(input logic [3:0] sel);
    {th, mxd, ovl, aw} <= sel;
    tick(1);
    {th, mxd, ovl, aw} <= 4'h0;
    tick(1);
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    tick(20);
    sys_rst <= 1'b0;
    tick(1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // hang guard, well beyond the ~25k cycles the tests take
  initial begin
    #400_000;
    error_cnt++;
    $display("Error run timeout");
    test_done;
  end
  // ==========================================================
  // tests
  initial begin
    rst;
    rchk("status", A_STATB, 32'hFFFF_FFFF, 32'h0000_0052);
    chk("pin_oe", 32'(pin_oe), 32'h0000_0001);
    chk("switches", 32'(sw), 32'h0000_0000);
    rres(5'h00, 32'h0000_FFFF);
    rchk("unmapped", 6'h07, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    // result clears
    ad <= 16'h1234;
    foreach (ix[k]) begin
      ai <= 5'(ix[k]);
      pulse(4'h1);
    end
    pulse(4'h2);
    pulse(4'h4);
    bus(1'b1, A_CFGA_LO, 32'hA5A5_A5A5);
    host.send(CMD_CLEAR_CELL_RESULTS_CMD, 1'b1);
    rres(5'h00, 32'h0000_FFFF);
    rres(5'h0E, 32'h0000_FFFF);
    rres(5'h10, 32'h0000_1234);
    host.send(CMD_CLEAR_AUXILIARY_CMD, 1'b1);
    rres(5'h10, 32'h0000_FFFF);
    rres(5'h19, 32'h0000_FFFF);
    rres(5'h1A, 32'h0000_1234);
    rchk("status", A_STATB, 32'hFFFF_FFFF, 32'h0000_0050);
    host.send(CMD_CLEAR_STATUS_CMD, 1'b1);
    rchk("status", A_STATB, 32'hFFFF_FFFF, 32'h0000_0053);
    rchk("ovuv", A_OVUV, 32'hFFFF_FFFF, 32'h3FFF_FFFF);
    rres(5'h1C, 32'h0000_FFFF);
    rres(5'h1F, 32'h0000_FFFF);
    rchk("cfga_lo", A_CFGA_LO, 32'hFFFF_FFFF, 32'hA5A5_A5A5);
    chk("thermal", 32'(thf), 32'h0000_0001);
    host.send(CMD_READ_STATUS_B_CMD, 1'b1);
    rchk("status", A_STATB, 32'hFFFF_FFFF, 32'h0000_0052);
    chk("thermal", 32'(thf), 32'h0000_0000);
    $display("test clears done");
    // thermal event
    bus(1'b1, A_CFGA_LO, 32'hFFFF_FFFF);
    bus(1'b1, A_CFGB, 32'h0000_80FF);
    pulse(4'h8);
    rchk("cfga_lo", A_CFGA_LO, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("cfgb", A_CFGB, 32'hFFFF_FFFF, 32'h0000_8000);
    chk("switches", 32'(sw), 32'h0000_0000);
    chk("thermal", 32'(thf), 32'h0000_0001);
    $display("test thermal done");
    // every timeout code reads back as its own bin right after loading
    rst;
    pin <= 1'b1;
    for (int c = 15; c >= 0; c--) begin
      bus(1'b1, A_CFGA_HI, {16'h0000, 4'(c), 12'h000});
      host.send(CMD_WRITE_CONFIG_A_CMD, 1'b1);
      rchk("timeout_code", A_CFGA_HI, 32'h0000_F000, {16'h0000, 4'(c), 12'h000});
      if (c == 15) rchk("dt_run", A_STATB, 32'h0000_0200, 32'h0000_0200);
    end
    $display("test codes done");
    // discharge expiry, ordinary command must not restart it
    rst;
    bus(1'b1, A_CFGA_LO, 32'hFFFF_FFFF);
    bus(1'b1, A_CFGB, 32'h0000_88FF);
    bus(1'b1, A_SWITCH_CONTROL_GROUP, 32'hFFFF_FFFF);
    bus(1'b1, A_CFGA_HI, 32'h0000_1FFF);
    host.send(CMD_WRITE_CONFIG_A_CMD, 1'b1);
    tick(80);
    chk("switches", 32'(sw), 32'h0000_7FFF);
    host.send(CMD_OTHER, 1'b1);
    tick(100);
    chk("switches", 32'(sw), 32'h0000_0000);
    rchk("cfga_lo", A_CFGA_LO, 32'hFFFF_FFFF, 32'h0000_00FF);
    rchk("cfga_hi", A_CFGA_HI, 32'h0000_FFFF, 32'h0000_0000);
    rchk("cfgb", A_CFGB, 32'hFFFF_FFFF, 32'h0000_800F);
    rchk("switch_control_group", A_SWITCH_CONTROL_GROUP, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test discharge done");
    // watchdog: timer running (monitor off, on), then timer disabled
    for (int i = 0; i < 3; i++) begin
      rst;
      pin <= (i < 2);
      bus(1'b1, A_CFGA_LO, 32'hFFFF_FFFF);
      bus(1'b1, A_CFGB, (i == 1) ? 32'h0000_08FF : 32'h0000_00FF);
      bus(1'b1, A_SWITCH_CONTROL_GROUP, 32'hFFFF_FFFF);
      bus(1'b1, A_CFGA_HI, 32'h0000_FFFF);
      host.send(CMD_WRITE_CONFIG_A_CMD, 1'b1);
      tick(4000);
      host.send(CMD_OTHER, 1'b0);
      tick(3900);
      chk("pin_oe", 32'(pin_oe), 32'h0000_0001);
      tick(150);
      chk("pin_oe", 32'(pin_oe), 32'h0000_0000);
      chk("pin_o", 32'(pin_o), 32'h0000_0000);
      el = (i == 1) ? 32'hFFFF_FF00 : 32'h0000_0000;
      eb = (i == 2) ? 32'h0000_0000 : ((i == 1) ? 32'h0000_08F0 : 32'h0000_00F0);
      rchk("wdt_expired", A_STATB, 32'h0000_0100, 32'h0000_0100);
      rchk("cfga_lo", A_CFGA_LO, 32'hFFFF_FFFF, el);
      rchk("cfgb", A_CFGB, 32'h0000_7FFF, eb);
      rchk("cfga_hi", A_CFGA_HI, 32'h0000_0FFF, (i == 2) ? 32'h0000_0000 : 32'h0000_0FFF);
      rchk("switch_control_group", A_SWITCH_CONTROL_GROUP, 32'hFFFF_FFFF, (i == 2) ? 32'h0000_0000 : 32'hFFFF_FFFF);
      chk("switches", 32'(sw), (i == 2) ? 32'h0000_0000 : 32'h0000_7FFF);
      host.send(CMD_OTHER, 1'b1);
      chk("pin_oe", 32'(pin_oe), 32'h0000_0001);
      $display("test watchdog %0d done", i);
    end
    test_done;
  end
endmodule
